// ==== design/pin_mux_pkg.sv ====
// shared constants, types and pin tables for the port C/D function mux
package pin_mux_pkg;

  // register indices and byte offsets
  localparam int unsigned REG_COUNT     = 6;
  localparam int unsigned IDX_PC_SEL_LO = 0;
  localparam int unsigned IDX_PC_SEL_HI = 1;
  localparam int unsigned IDX_PD_SEL_LO = 2;
  localparam int unsigned IDX_PD_SEL_HI = 3;
  localparam int unsigned IDX_HALL_ROUTE = 4;
  localparam int unsigned IDX_SER_ROUTE = 5;

  localparam logic [7:0] OFS_PC_SEL_LO  = 8'h00;
  localparam logic [7:0] OFS_PC_SEL_HI  = 8'h04;
  localparam logic [7:0] OFS_PD_SEL_LO  = 8'h08;
  localparam logic [7:0] OFS_PD_SEL_HI  = 8'h0C;
  localparam logic [7:0] OFS_HALL_ROUTE = 8'h10;
  localparam logic [7:0] OFS_SER_ROUTE  = 8'h14;

  // reset values and implemented-bit masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] REG_MASK [REG_COUNT] = '{
    8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h1F};

  // field positions in the serial/irq route register
  localparam int unsigned SER_ROUTE_BIT = 4;
  localparam int unsigned RSVD_LSB      = 2;
  localparam int unsigned IRQ_ROUTE_LSB = 0;

  // irq route codes and the gpio selector code
  localparam logic [1:0] IRQ_FROM_A7  = 2'h0;
  localparam logic [1:0] IRQ_FROM_D7  = 2'h3;
  localparam logic [1:0] SEL_GPIO     = 2'h0;

  // bus answer timing: one wait state in every access phase
  localparam int unsigned APB_WAIT_CYCLES = 1;

  // pin functions a selector can choose
  typedef enum logic [4:0] {
    FN_GPIO,
    FN_GAT, FN_GAB, FN_GBT, FN_GBB, FN_GCT, FN_GCB,
    FN_T0, FN_T0B, FN_T1, FN_T1B, FN_T2, FN_T2B, FN_T3, FN_T3B,
    FN_HA, FN_HB, FN_HC,
    FN_SER_TX, FN_SER_IO
  } pin_fn_e;

  typedef struct packed {
    logic aUp;
    logic aLo;
    logic bUp;
    logic bLo;
    logic cUp;
    logic cLo;
  } gate_s;

  // alternate function sources offered to the pins
  typedef struct packed {
    gate_s      gate;
    logic [3:0] tmr;
    logic [2:0] hall;
    logic       serTx;
    logic       serIo;
  } alt_src_s;

  // per pin: selector register, field lsb, function for codes 0..3
  localparam int unsigned PC_REG [8] = '{0, 0, 0, 0, 1, 1, 0, 0};
  localparam int unsigned PC_LSB [8] = '{0, 0, 4, 0, 0, 2, 0, 0};
  localparam pin_fn_e PC_MAP [8][4] = '{
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_GBT,  FN_GBB,  FN_GAB },
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_GCT,  FN_GAB,  FN_GCB },
    '{FN_GPIO, FN_GCB,  FN_GAT,  FN_GBB },
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO},
    '{FN_GPIO, FN_GPIO, FN_GPIO, FN_GPIO}};

  localparam int unsigned PD_REG [8] = '{2, 2, 2, 2, 3, 3, 3, 3};
  localparam int unsigned PD_LSB [8] = '{0, 2, 4, 6, 0, 2, 4, 6};
  localparam pin_fn_e PD_MAP [8][4] = '{
    '{FN_GPIO, FN_T0B, FN_T0,  FN_SER_TX},
    '{FN_GPIO, FN_T0,  FN_HC,  FN_SER_IO},
    '{FN_GPIO, FN_T1B, FN_HB,  FN_GAT   },
    '{FN_GPIO, FN_T1,  FN_HA,  FN_GAB   },
    '{FN_GPIO, FN_T2B, FN_T1,  FN_GBT   },
    '{FN_GPIO, FN_T2,  FN_T1B, FN_GBB   },
    '{FN_GPIO, FN_T3B, FN_T0,  FN_GCT   },
    '{FN_GPIO, FN_T3,  FN_T0B, FN_GCB   }};

endpackage : pin_mux_pkg

// ==== design/port_cd_pin_function_mux.sv ====
// port C/D pin function mux with APB register file and input routing
//
// Behaviour
// - port C bit 2: 00 gpio, 01 phase B upper, 10 phase B lower, 11 A lower
// - second port C select register: bits 7..4 read zero
// - port C bit 5: 00 gpio, 01 C lower, 10 A upper, 11 B lower
// - port C bit 4: 00 gpio, 01 C upper, 10 A lower, 11 C lower
// - port D bit 3: gpio/clk0, timer1, hall A, phase A lower
// - port D bit 2: gpio/clk1, timer1 inverted, hall B, phase A upper
// - port D bit 1: gpio/clk2/irq, timer0, hall C, serial rx/tx
// - port D bit 0: gpio/clk3/capture, timer0 inv, timer0, serial tx
// - port D bit 7: gpio/clk0/irq, timer3, timer0 inv, phase C lower
// - port D bit 6: gpio/clk1/capture, timer3 inv, timer0, phase C upper
// - port D bit 5: gpio/clk2, timer2, timer1 inv, phase B lower
// - port D bit 4: gpio/clk3, timer2 inv, timer1, phase B upper
// - serial input from port B bit 4 (0) or port D bit 1 (1)
// - irq source: 00 port A bit 7, 01/10 port D bit 1, 11 D bit 7
// - serial/irq route register bits 7..5 read zero
// - pin in clock function feeds timer clock or event count
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module port_cd_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        portCGpioOut,
  input  wire logic [7:0]        portDGpioOut,
  input  wire alt_src_s          altSrc,
  input  wire logic [7:0]        portDPinIn,
  input  wire logic              portAPin7In,
  input  wire logic              portBPin4In,
  output logic      [7:0]        portCPinOut,
  output logic      [7:0]        portCAltActive,
  output logic      [7:0]        portDPinOut,
  output logic      [7:0]        portDAltActive,
  output logic                   serialRxIn,
  output logic                   extIrqIn,
  output logic      [7:0]        timerClkPinD,
  output logic      [1:0]        capturePinD
);

  generate
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 5 and 32");
    end
  endgenerate

  // register index is three bits wide
  generate
    if (REG_COUNT > 8) begin : g_bad_count
      $error("REG_COUNT must not exceed 8");
    end
  endgenerate

  // answer logic serves exactly one wait state
  generate
    if (APB_WAIT_CYCLES != 1) begin : g_bad_wait
      $error("APB_WAIT_CYCLES must be 1");
    end
  endgenerate

  // pin tables must point at real selector fields
  genvar t;
  generate
    for (t = 0; t < 8; t++) begin : g_tab_chk
      if (PC_REG[t] >= REG_COUNT || PD_REG[t] >= REG_COUNT) begin : g_bad_reg
        $error("pin table names a missing register");
      end
      if (PC_LSB[t] > 6 || PD_LSB[t] > 6) begin : g_bad_lsb
        $error("pin table field runs past bit 7");
      end
    end
  endgenerate

  // reset values must fit the implemented bits
  genvar m;
  generate
    for (m = 0; m < REG_COUNT; m++) begin : g_rst_chk
      if ((REG_RESET & ~REG_MASK[m]) != 8'h00) begin : g_bad_rst
        $error("reset value sets an unimplemented bit");
      end
    end
  endgenerate

  // value a pin shows for a chosen function
  function automatic logic fnValue(input pin_fn_e fn,
                                   input alt_src_s src,
                                   input logic gpio);
    logic v;
    v = gpio;
    case (fn)
      FN_GAT:    v = src.gate.aUp;
      FN_GAB:    v = src.gate.aLo;
      FN_GBT:    v = src.gate.bUp;
      FN_GBB:    v = src.gate.bLo;
      FN_GCT:    v = src.gate.cUp;
      FN_GCB:    v = src.gate.cLo;
      FN_T0:     v = src.tmr[0];
      FN_T0B:    v = ~src.tmr[0];
      FN_T1:     v = src.tmr[1];
      FN_T1B:    v = ~src.tmr[1];
      FN_T2:     v = src.tmr[2];
      FN_T2B:    v = ~src.tmr[2];
      FN_T3:     v = src.tmr[3];
      FN_T3B:    v = ~src.tmr[3];
      FN_HA:     v = src.hall[0];
      FN_HB:     v = src.hall[1];
      FN_HC:     v = src.hall[2];
      FN_SER_TX: v = src.serTx;
      FN_SER_IO: v = src.serIo;
      default:   v = gpio;
    endcase
    return v;
  endfunction : fnValue

  // irq source for a route code; 01 and 10 both take port D bit 1
  function automatic logic irqPick(input logic [1:0] code,
                                   input logic       a7,
                                   input logic       d1,
                                   input logic       d7);
    logic v;
    v = d1;
    case (code)
      IRQ_FROM_A7: v = a7;
      IRQ_FROM_D7: v = d7;
      default:     v = d1;
    endcase
    return v;
  endfunction : irqPick

  // serial input: port B bit 4 or port D bit 1
  function automatic logic serPick(input logic fromD1,
                                   input logic b4,
                                   input logic d1);
    return fromD1 ? d1 : b4;
  endfunction : serPick

  // two-bit selector field of a select register
  function automatic logic [1:0] selField(input logic [7:0]  regVal,
                                          input int unsigned lsb);
    logic [1:0] f;
    f = regVal[lsb +: 2];
    return f;
  endfunction : selField

  // register storage
  logic [7:0] regFile_ff [REG_COUNT];
  logic [7:0] nxt_regFile [REG_COUNT];
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  // bus decode
  wire logic [ADDR_W-3:0] wordIdx   = paddr[ADDR_W-1:2];
  wire logic              alignedOk = (paddr[1:0] == 2'h0);
  wire logic              mapped    = alignedOk &&
                                      (wordIdx < (ADDR_W-2)'(REG_COUNT));
  wire logic [2:0]        regIdx    = wordIdx[2:0];
  wire logic              accessReq = psel && penable;
  wire logic              firstAcc  = accessReq && !pready_ff;
  wire logic              doWrite   = accessReq && pready_ff && pwrite &&
                                      mapped && pstrb[0];
  wire logic [7:0]        regRead   = regFile_ff[regIdx];
  wire logic [31:0]       readWord  = mapped ?
                                      {24'h00_0000, regRead} :
                                      32'h0000_0000;

  // writes land at the completing edge; masked bits store zero
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      nxt_regFile[i] = regFile_ff[i];
    end
    if (doWrite) begin
      nxt_regFile[regIdx] = pwdata[7:0] & REG_MASK[regIdx];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile_ff[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile_ff[i] <= nxt_regFile[i];
      end
    end
  end

  // one wait state, data and error valid with pready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= firstAcc;
    end
  end

  // error flag for holes and unaligned words
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= firstAcc && !mapped;
    end
  end

  // read data stands only with pready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= (firstAcc && !pwrite) ? readWord : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // pin function selection
  logic [7:0] pcOut_ff;
  logic [7:0] pcAlt_ff;
  logic [7:0] pdOut_ff;
  logic [7:0] pdAlt_ff;
  logic [7:0] clkPin_ff;
  logic [7:0] pcOutNxt;
  logic [7:0] pcAltNxt;
  logic [7:0] pdOutNxt;
  logic [7:0] pdAltNxt;
  logic [7:0] clkPinNxt;
  logic [7:0] pdIsGpio;

  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_pin_c
      wire logic [7:0] pcReg = regFile_ff[PC_REG[p]];
      wire logic [1:0] pcSel = selField(pcReg, PC_LSB[p]);
      wire pin_fn_e    pcFn  = PC_MAP[p][pcSel];
      assign pcOutNxt[p] = fnValue(pcFn, altSrc, portCGpioOut[p]);
      assign pcAltNxt[p] = (pcFn != FN_GPIO);
    end
  endgenerate

  genvar q;
  generate
    for (q = 0; q < 8; q++) begin : g_pin_d
      wire logic [7:0] pdReg = regFile_ff[PD_REG[q]];
      wire logic [1:0] pdSel = selField(pdReg, PD_LSB[q]);
      wire pin_fn_e    pdFn  = PD_MAP[q][pdSel];
      assign pdOutNxt[q] = fnValue(pdFn, altSrc, portDGpioOut[q]);
      assign pdAltNxt[q] = (pdFn != FN_GPIO);
      assign pdIsGpio[q] = (pdSel == SEL_GPIO);
    end
  endgenerate

  // timer clock candidates: pin level only while the pin stays gpio
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_clk_pin
      assign clkPinNxt[k] = pdIsGpio[k] & portDPinIn[k];
    end
  endgenerate

  // input routing
  wire logic [7:0] serRoute  = regFile_ff[IDX_SER_ROUTE];
  wire logic [1:0] irqRoute  = serRoute[IRQ_ROUTE_LSB +: 2];
  wire logic       serFromD1 = serRoute[SER_ROUTE_BIT];
  wire logic       serRxNxt  = serPick(serFromD1, portBPin4In,
                                       portDPinIn[1]);
  wire logic       irqNxt    = irqPick(irqRoute, portAPin7In,
                                       portDPinIn[1], portDPinIn[7]);
  // capture candidates on port D bits 0 and 6
  wire logic       capPin0   = pdIsGpio[0] & portDPinIn[0];
  wire logic       capPin6   = pdIsGpio[6] & portDPinIn[6];
  wire logic [1:0] capNxt    = {capPin6, capPin0};

  logic       serRx_ff;
  logic       irq_ff;
  logic [1:0] cap_ff;

  // registered pin and routing outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pcOut_ff <= 8'h00;
    end else begin
      pcOut_ff <= pcOutNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pcAlt_ff <= 8'h00;
    end else begin
      pcAlt_ff <= pcAltNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pdOut_ff <= 8'h00;
    end else begin
      pdOut_ff <= pdOutNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pdAlt_ff <= 8'h00;
    end else begin
      pdAlt_ff <= pdAltNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clkPin_ff <= 8'h00;
    end else begin
      clkPin_ff <= clkPinNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serRx_ff <= 1'b0;
    end else begin
      serRx_ff <= serRxNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irqNxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_ff <= 2'h0;
    end else begin
      cap_ff <= capNxt;
    end
  end

  assign portCPinOut    = pcOut_ff;
  assign portCAltActive = pcAlt_ff;
  assign portDPinOut    = pdOut_ff;
  assign portDAltActive = pdAlt_ff;
  assign serialRxIn     = serRx_ff;
  assign extIrqIn       = irq_ff;
  assign timerClkPinD   = clkPin_ff;
  assign capturePinD    = cap_ff;

endmodule : port_cd_pin_function_mux

// ==== tb/port_cd_mux_assertions.sv ====
// assertions on the ports of the port C/D pin function mux
`timescale 1ns/10ps
module port_cd_mux_check
  import pin_mux_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic [7:0]        portDGpioOut,
  input wire logic [7:0]        portDPinIn,
  input wire logic              portAPin7In,
  input wire logic              portBPin4In,
  input wire logic [7:0]        portDPinOut,
  input wire logic [7:0]        portDAltActive,
  input wire logic              serialRxIn,
  input wire logic              extIrqIn,
  input wire logic [7:0]        timerClkPinD,
  input wire logic [1:0]        capturePinD
);
  logic [4:0] routeMirror_ff;
  wire        rdAck = pready && !pwrite;
  wire        routeWr = rdAck == 1'b0 && pready && psel && penable
                        && pstrb[0] && paddr == ADDR_W'(OFS_SER_ROUTE);
  wire [1:0]  irqCode = routeMirror_ff[1:0];
  wire        irqPick = irqCode == IRQ_FROM_A7 ? portAPin7In
                      : irqCode == IRQ_FROM_D7 ? portDPinIn[7]
                      : portDPinIn[1];
  wire        serPick = routeMirror_ff[SER_ROUTE_BIT] ? portDPinIn[1]
                                                      : portBPin4In;
  // shadow of the serial/irq route register
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      routeMirror_ff <= 5'h00;
    else if (routeWr)
      routeMirror_ff <= pwdata[4:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_GPIO_KEPT: assert property (!$past(reset) |->
    (portDPinOut & ~portDAltActive)
      == ($past(portDGpioOut) & ~portDAltActive))
    else $error("port D gpio value not passed");
  AST_TMR_CLK: assert property (!$past(reset) |->
    timerClkPinD == ($past(portDPinIn) & ~portDAltActive))
    else $error("timer clock pin level wrong");
  AST_CAPTURE: assert property (!$past(reset) |->
    capturePinD == {$past(portDPinIn[6]) & ~portDAltActive[6],
                    $past(portDPinIn[0]) & ~portDAltActive[0]})
    else $error("capture pin level wrong");
  AST_SER_ROUTE: assert property (!$past(reset) |->
    serialRxIn == $past(serPick))
    else $error("serial input from wrong pin");
  AST_IRQ_ROUTE: assert property (!$past(reset) |->
    extIrqIn == $past(irqPick))
    else $error("irq input from wrong pin");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ANSWER: assert property ($rose(penable) && psel |-> ##[0:2] pready)
    else $error("bus answer missing");
  AST_PCHI_ZERO: assert property (rdAck
    && paddr == ADDR_W'(OFS_PC_SEL_HI) |-> prdata[31:4] == 28'h000_0000)
    else $error("port C high select upper bits not zero");
  AST_SERHI_ZERO: assert property (rdAck
    && paddr == ADDR_W'(OFS_SER_ROUTE) |-> prdata[31:5] == 27'h000_0000)
    else $error("route register upper bits not zero");
endmodule : port_cd_mux_check

// ==== tb/tb_port_cd_pin_function_mux.sv ====
// self-checking bench for the port C/D pin function mux
`timescale 1ns/10ps
module tb_port_cd_pin_function_mux
  import pin_mux_pkg::*;
;
  localparam int unsigned ADDR_W = 12;
  // per pin D0..D7, C2, C4, C5 and code 1..3: {invert, source bit}
  localparam logic [7:0] FN_TAB [33] = '{
    8'h15, 8'h05, 8'h01, 8'h05, 8'h04, 8'h00, 8'h16, 8'h03, 8'h0E,
    8'h06, 8'h02, 8'h0D, 8'h17, 8'h06, 8'h0C, 8'h07, 8'h16, 8'h0B,
    8'h18, 8'h05, 8'h0A, 8'h08, 8'h15, 8'h09, 8'h0C, 8'h0B, 8'h0D,
    8'h0A, 8'h0D, 8'h09, 8'h09, 8'h0E, 8'h0B};
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [3:0]        pstrb = '0;
  logic [7:0]        portCGpioOut = '0;
  logic [7:0]        portDGpioOut = '0;
  logic [7:0]        portDPinIn = '0;
  alt_src_s          altSrc = '0;
  logic              portAPin7In = 1'b0;
  logic              portBPin4In = 1'b0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, er, serialRxIn, extIrqIn;
  logic [7:0]        portCPinOut, portCAltActive, portDPinOut, portDAltActive;
  logic [7:0]        timerClkPinD;
  logic [1:0]        capturePinD;
  int                err_total = 0;
  int                total_checks = 0;

  port_cd_pin_function_mux #(.ADDR_W(ADDR_W)) i_port_cd_pin_function_mux (.*);
  initial forever #2 clk = ~clk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ADDR_W'(a);
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_total++;
        print_verdict();
      end
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic pick(input logic [7:0] d, input logic [7:0] c,
                                input int p);
    if (p < 8)
      return d[p];
    return c[p == 8 ? 2 : p == 9 ? 4 : 5];
  endfunction : pick

  task automatic test_regs;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, 4'h0);
      check(rd, 32'h0);
      check(er, 1'b0);
    end
    apb(1'b0, 8'h18, 32'h0, 4'h0);
    check(er, 1'b1);
    apb(1'b1, OFS_PC_SEL_HI, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, OFS_PC_SEL_HI, 32'h0, 4'h0);
    check(rd, 32'h0000_000F);
    apb(1'b1, OFS_SER_ROUTE, 32'h0000_00F3, 4'hF);
    apb(1'b0, OFS_SER_ROUTE, 32'h0, 4'h0);
    check(rd, 32'h0000_0013);
    apb(1'b1, OFS_PD_SEL_LO, 32'h0000_00FF, 4'h0);
    apb(1'b0, OFS_PD_SEL_LO, 32'h0, 4'h0);
    check(rd, 32'h0);
  endtask : test_regs

  task automatic test_pins;
    logic [7:0]  e;
    logic [14:0] oh;
    logic        lv;
    logic        got;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFS_PD_SEL_LO, {24'h0, {4{c[1:0]}}}, 4'h1);
      apb(1'b1, OFS_PD_SEL_HI, {24'h0, {4{c[1:0]}}}, 4'h1);
      apb(1'b1, OFS_PC_SEL_LO, {26'h0, c[1:0], 4'h0}, 4'h1);
      apb(1'b1, OFS_PC_SEL_HI, {28'h0, {2{c[1:0]}}}, 4'h1);
      portDPinIn <= 8'hC3;
      portDGpioOut <= 8'h5A;
      portCGpioOut <= 8'hA5;
      altSrc <= '1;
      settle();
      check(timerClkPinD, c == 0 ? 8'hC3 : 8'h00);
      check(capturePinD, c == 0 ? 2'h3 : 2'h0);
      check(portCAltActive, c == 0 ? 8'h00 : 8'h34);
      check(portDAltActive, c == 0 ? 8'h00 : 8'hFF);
      if (c == 0) begin
        check(portDPinOut, 8'h5A);
        check(portCPinOut, 8'hA5);
      end
      for (int p = 0; p < 11 && c > 0; p++) begin
        for (int k = 0; k < 2; k++) begin
          e = FN_TAB[p * 3 + c - 1];
          oh = 15'h0001 << e[3:0];
          lv = k[0] ^ e[4];
          altSrc <= k[0] ? oh : ~oh;
          portDGpioOut <= {8{~lv}};
          portCGpioOut <= {8{~lv}};
          settle();
          got = pick(portDPinOut, portCPinOut, p);
          check(got, lv);
        end
      end
    end
  endtask : test_pins

  task automatic test_route;
    logic [7:0] d;
    logic       a7;
    logic       b4;
    logic       k;
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, OFS_SER_ROUTE, {27'h0, v[2], 2'b00, v[1:0]}, 4'h1);
      for (int j = 0; j < 4; j++) begin
        k = j[0];
        d = {8{~k}};
        a7 = ~k;
        b4 = ~k;
        if (j < 2 && v[1:0] == 2'h0)
          a7 = k;
        else if (j < 2 && v[1:0] == 2'h3)
          d[7] = k;
        else if (j < 2 || v[2])
          d[1] = k;
        else
          b4 = k;
        portDPinIn <= d;
        portAPin7In <= a7;
        portBPin4In <= b4;
        settle();
        if (j < 2)
          check(extIrqIn, k);
        else
          check(serialRxIn, k);
      end
    end
  endtask : test_route

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_pins();
    test_route();
    print_verdict();
  end
endmodule : tb_port_cd_pin_function_mux

bind port_cd_pin_function_mux port_cd_mux_check #(.ADDR_W(ADDR_W))
  i_port_cd_mux_check (.*);
